// ==== epw_defs.svh ====
// Register offsets, field positions, reset values and image layout
`ifndef EPW_DEFS_SVH
`define EPW_DEFS_SVH
`define EPW_OFS_IDENT       12'h930
`define EPW_OFS_LATENCY     12'h934
`define EPW_OFS_UID_HIGH    12'h938
`define EPW_OFS_UID_LOW     12'h93C
`define EPW_OFS_PARAM_WRITE 12'h940
`define EPW_OFS_USER0       12'h950
`define EPW_OFS_USER3       12'h95C
`define EPW_OFS_PHY_OPTION  12'h960
`define EPW_OFS_CARD_EVEN   12'h980
`define EPW_OFS_CARD_ODD    12'h984
`define EPW_TRIG_BIT        0
`define EPW_PAGE_MSB        6
`define EPW_PAGE_LSB        4
`define EPW_PHY_PROG_BIT    9
`define EPW_PHY_ENH_BIT     8
`define EPW_RST_IDENT       32'h0063_1033
`define EPW_RST_LATENCY     32'h0000_0809
`define EPW_RST_PHY_OPTION  32'h0000_0200
`define EPW_IMG_IDENT       8'h00
`define EPW_IMG_UID         8'h08
`define EPW_IMG_USER01      8'h10
`define EPW_IMG_USER23      8'h18
`define EPW_IMG_PHY         8'h20
`define EPW_IMG_CARD        8'h28
`define EPW_IMG_WORDS       42
`define EPW_CARD_WORDS      32
`define EPW_PAGE_BYTES      8
`define EPW_WAIT_MS         13
`endif

// ==== epw_ee_model.sv ====
// Behavioural serial EEPROM and its after-reset reader
`timescale 1ns/1ps
`default_nettype none
module epw_ee_model (
  input  wire logic               clock,
  input  wire logic               slow,
  input  wire logic               reload,
  input  wire logic               ee_valid,
  input  wire epw_pkg::epw_byte_t ee_byte,
  output logic                    ee_ready,
  output epw_pkg::epw_load_t      ld_byte
);
  logic [7:0] mem [0:255];
  logic [1:0] div = 2'h0;
  logic [7:0] ptr = 8'hA8;
  int         cnt = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  // Slow mode accepts one byte in four cycles
  assign ee_ready = ee_valid && (!slow || div == 2'h3);
  always @(posedge clock) begin
    div <= div + 2'h1;
    if (ee_valid && ee_ready) begin
      mem[ee_byte.addr] <= ee_byte.data;
      cnt <= cnt + 1;
    end
    if (reload) ptr <= 8'h00;
    else if (ptr < 8'hA8) ptr <= ptr + 8'h01;
  end
  assign ld_byte.valid = ptr < 8'hA8;
  assign ld_byte.addr = ptr;
  assign ld_byte.data = ld_byte.valid ? mem[ptr] : {4{div}};
endmodule
`default_nettype wire

// ==== epw_page_writer.sv ====
// Parameter staging registers, EEPROM page writer and image load-back
//
// Operation
// - Three-bit page selector sits in bits 6..4 of parameter write reg.
// - Page selector field always reads back as zero.
// - Code 0 picks identifiers and latency; code 1 picks unique id pair.
// - Code 2 picks user words 0 and 1; code 3 picks words 2 and 3.
// - Code 4 picks PHY option word; code 5 picks card info pair.
// - Writing one to bit 0 starts a page write for codes 0..5 when idle; zero does nothing.
// - Every page write sends exactly eight bytes: two staged words, or for code 4 PHY bits 9..0 and zeros.
// - Trigger bit always reads back as zero.
// - Low unique id shadow feeds the link low unique id register.
// - Four user words at consecutive addresses feed config 70h..7Fh.
// - PHY programming enable at bit 9, resets one, feeds control bit 23.
// - PHY enhancement enable at bit 8, resets zero, feeds bit 23.
// - Card info pair feeds configuration card info area 80h..FCh.
// - Image stores words MSB first at the documented byte addresses.
// - Targets load from the EEPROM after reset, not after a write.
`include "epw_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module epw_page_writer #(
  parameter int CARD_PAIRS = 16
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [11:0]        reg_addr,
  input  wire logic [31:0]        reg_wdata,
  output logic      [31:0]        reg_rdata,
  output logic                    write_busy,
  output logic                    ee_valid,
  input  wire logic               ee_ready,
  output epw_pkg::epw_byte_t      ee_byte,
  input  wire epw_pkg::epw_load_t ld_byte,
  output logic      [31:0]        subsys_ident_reg,
  output logic      [31:0]        latency_reg,
  output logic      [31:0]        unique_id_high_reg,
  output logic      [31:0]        unique_id_low_reg,
  output logic      [127:0]       user_cfg_reg,
  output logic                    phy_prog_enable_bit,
  output logic                    phy_enhance_bit,
  input  wire logic [4:0]         card_rd_idx,
  output logic      [31:0]        card_rd_data
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Byte n of a word pair, most significant byte first
  function automatic logic [7:0] pair_byte(input logic [63:0] pair,
                                           input logic [2:0]  n);
    pair_byte = pair[8'(63 - 8 * n) -: 8];
  endfunction

  // Replace one byte lane; lane 0 is bits 31..24
  function automatic logic [31:0] put_lane(input logic [31:0] w,
                                           input logic [1:0]  lane,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = w;
    r[8'(31 - 8 * lane) -: 8] = b;
    put_lane = r;
  endfunction

  // Word-aligned hit in the user word window
  function automatic logic user_hit(input logic [11:0] a);
    user_hit = a >= `EPW_OFS_USER0 && a <= `EPW_OFS_USER3 &&
               a[1:0] == 2'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Shadow registers

  logic [31:0]               subsystem_ident_shadow_reg;
  logic [31:0]               latency_shadow_reg;
  logic [31:0]               uid_high_shadow_reg;
  logic [31:0]               uid_low_shadow_reg;
  logic [31:0]               user_shadow_reg [0:3];
  logic [31:0]               phy_shadow_reg;
  logic [31:0]               card_even_reg;
  logic [31:0]               card_odd_reg;
  logic [3:0]                card_pair_reg;
  logic                      trig_hit;
  epw_pkg::epw_page_t        page_sel;
  epw_pkg::epw_state_t       state_reg;

  assign page_sel = epw_pkg::epw_page_t'(
                      reg_wdata[`EPW_PAGE_MSB:`EPW_PAGE_LSB]);
  // Trigger ignored while a page is in flight
  assign trig_hit = reg_wr && reg_addr == `EPW_OFS_PARAM_WRITE &&
                    reg_wdata[`EPW_TRIG_BIT] &&
                    state_reg == epw_pkg::EPW_ST_IDLE;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      subsystem_ident_shadow_reg <= `EPW_RST_IDENT;
      latency_shadow_reg  <= `EPW_RST_LATENCY;
      uid_high_shadow_reg <= 32'h0000_0000;
      uid_low_shadow_reg  <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        user_shadow_reg[i] <= 32'h0000_0000;
      end
      phy_shadow_reg      <= `EPW_RST_PHY_OPTION;
      card_even_reg       <= 32'h0000_0000;
      card_odd_reg        <= 32'h0000_0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `EPW_OFS_IDENT:      subsystem_ident_shadow_reg <= reg_wdata;
        `EPW_OFS_LATENCY:    latency_shadow_reg <= reg_wdata;
        `EPW_OFS_UID_HIGH:   uid_high_shadow_reg <= reg_wdata;
        `EPW_OFS_UID_LOW:    uid_low_shadow_reg <= reg_wdata;
        `EPW_OFS_PHY_OPTION: phy_shadow_reg     <= reg_wdata;
        `EPW_OFS_CARD_EVEN:  card_even_reg      <= reg_wdata;
        `EPW_OFS_CARD_ODD:   card_odd_reg       <= reg_wdata;
        default: begin
          if (user_hit(reg_addr)) begin
            user_shadow_reg[reg_addr[3:2]] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // Card pair index advances at each card info page trigger
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      card_pair_reg <= 4'h0;
    end else if (trig_hit && page_sel == epw_pkg::EPW_PG_CARD) begin
      card_pair_reg <= (card_pair_reg == 4'(CARD_PAIRS - 1)) ?
                       4'h0 : card_pair_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `EPW_OFS_IDENT:       reg_rdata <= subsystem_ident_shadow_reg;
        `EPW_OFS_LATENCY:     reg_rdata <= latency_shadow_reg;
        `EPW_OFS_UID_HIGH:    reg_rdata <= uid_high_shadow_reg;
        `EPW_OFS_UID_LOW:     reg_rdata <= uid_low_shadow_reg;
        `EPW_OFS_PARAM_WRITE: reg_rdata <= 32'h0000_0000;
        `EPW_OFS_PHY_OPTION:  reg_rdata <= phy_shadow_reg;
        `EPW_OFS_CARD_EVEN:   reg_rdata <= card_even_reg;
        `EPW_OFS_CARD_ODD:    reg_rdata <= card_odd_reg;
        default: begin
          if (user_hit(reg_addr)) begin
            reg_rdata <= user_shadow_reg[reg_addr[3:2]];
          end else begin
            reg_rdata <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Page selection and snapshot

  logic [63:0] page_data;
  logic [7:0]  page_base;

  always_comb begin
    page_data = 64'h0;
    page_base = `EPW_IMG_IDENT;
    case (page_sel)
      epw_pkg::EPW_PG_IDENT: begin
        page_data = {subsystem_ident_shadow_reg, latency_shadow_reg};
        page_base = `EPW_IMG_IDENT;
      end
      epw_pkg::EPW_PG_UID: begin
        page_data = {uid_high_shadow_reg, uid_low_shadow_reg};
        page_base = `EPW_IMG_UID;
      end
      epw_pkg::EPW_PG_USR01: begin
        page_data = {user_shadow_reg[0], user_shadow_reg[1]};
        page_base = `EPW_IMG_USER01;
      end
      epw_pkg::EPW_PG_USR23: begin
        page_data = {user_shadow_reg[2], user_shadow_reg[3]};
        page_base = `EPW_IMG_USER23;
      end
      // Byte 22h holds the two PHY bits
      epw_pkg::EPW_PG_PHY: begin
        page_data = {16'h0000, 6'h00,
                     phy_shadow_reg[`EPW_PHY_PROG_BIT],
                     phy_shadow_reg[`EPW_PHY_ENH_BIT],
                     phy_shadow_reg[7:0], 32'h0000_0000};
        page_base = `EPW_IMG_PHY;
      end
      epw_pkg::EPW_PG_CARD: begin
        page_data = {card_even_reg, card_odd_reg};
        page_base = 8'(`EPW_IMG_CARD + 8 * card_pair_reg);
      end
      default: begin
        page_data = 64'h0;
        page_base = `EPW_IMG_IDENT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Page send engine

  logic [63:0] snap_reg;
  logic [7:0]  base_reg;
  logic [2:0]  cnt_reg;
  logic        page_ok;
  logic        page_go;

  // Codes 6 and 7 start nothing
  assign page_ok = page_sel <= epw_pkg::EPW_PG_CARD;
  assign page_go = trig_hit && page_ok;

  // Snapshot taken at the trigger; later shadow writes do not leak in
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      snap_reg <= 64'h0;
      base_reg <= 8'h00;
    end else if (page_go) begin
      snap_reg <= page_data;
      base_reg <= page_base;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= epw_pkg::EPW_ST_IDLE;
      cnt_reg   <= 3'h0;
    end else begin
      case (state_reg)
        epw_pkg::EPW_ST_IDLE: begin
          if (page_go) begin
            cnt_reg   <= 3'h0;
            state_reg <= epw_pkg::EPW_ST_SEND;
          end
        end
        epw_pkg::EPW_ST_SEND: begin
          if (ee_ready) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'(`EPW_PAGE_BYTES - 1)) begin
              state_reg <= epw_pkg::EPW_ST_IDLE;
            end
          end
        end
        default: state_reg <= epw_pkg::EPW_ST_IDLE;
      endcase
    end
  end

  assign write_busy    = state_reg == epw_pkg::EPW_ST_SEND;
  assign ee_valid      = write_busy;
  assign ee_byte.addr  = base_reg + {5'h00, cnt_reg};
  assign ee_byte.data  = pair_byte(snap_reg, cnt_reg);
  assign ee_byte.last  = cnt_reg == 3'(`EPW_PAGE_BYTES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Load-back image, fed by the EEPROM reader after reset only

  logic [31:0] img_reg [0:`EPW_IMG_WORDS-1];
  logic [5:0]  ld_word;

  assign ld_word = ld_byte.addr[7:2];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `EPW_IMG_WORDS; i++) begin
        img_reg[i] <= 32'h0000_0000;
      end
      img_reg[8] <= 32'h0000_0200;
    end else if (ld_byte.valid && ld_word < 6'(`EPW_IMG_WORDS)) begin
      img_reg[ld_word] <= put_lane(img_reg[ld_word],
                                   ld_byte.addr[1:0], ld_byte.data);
    end
  end

  assign subsys_ident_reg    = img_reg[0];
  assign latency_reg         = img_reg[1];
  assign unique_id_high_reg  = img_reg[2];
  assign unique_id_low_reg   = img_reg[3];
  assign user_cfg_reg        = {img_reg[7], img_reg[6],
                                img_reg[5], img_reg[4]};
  assign phy_prog_enable_bit = img_reg[8][`EPW_PHY_PROG_BIT];
  assign phy_enhance_bit     = img_reg[8][`EPW_PHY_ENH_BIT];

  // Card words start at image word 10
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      card_rd_data <= 32'h0000_0000;
    end else begin
      card_rd_data <= img_reg[6'd10 + {1'b0, card_rd_idx}];
    end
  end

endmodule
`default_nettype wire

// ==== epw_page_writer_bench.sv ====
// Self-checking bench for the parameter page writer
`timescale 1ns/1ps
`default_nettype none
module epw_page_writer_bench;
  typedef struct {
    logic [2:0]  page;
    logic [11:0] oa;
    logic [31:0] wa;
    logic [11:0] ob;
    logic [31:0] wb;
    logic [7:0]  base;
    logic [63:0] img;
  } epw_row_t;
  epw_row_t           rows [7];
  logic               clock = 1'b0;
  logic               reset_n = 1'b0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               slow = 1'b0;
  logic               reload = 1'b0;
  logic [11:0]        reg_addr = 12'h000;
  logic [31:0]        reg_wdata = 32'h0;
  logic [4:0]         card_rd_idx = 5'h00;
  logic [31:0]        reg_rdata, card_rd_data, unique_id_low_reg;
  logic [31:0]        subsys_ident_reg, latency_reg, unique_id_high_reg;
  logic [127:0]       user_cfg_reg;
  logic               write_busy, ee_valid, ee_ready;
  logic               phy_prog_enable_bit, phy_enhance_bit;
  epw_pkg::epw_byte_t ee_byte;
  epw_pkg::epw_load_t ld_byte;
  int                 bad_count = 0;
  int                 checked = 0;
  int                 n0;
  epw_page_writer epw_page_writer_i (.clock, .reset_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .write_busy, .ee_valid, .ee_ready,
    .ee_byte, .ld_byte, .subsys_ident_reg, .latency_reg,
    .unique_id_high_reg, .unique_id_low_reg, .user_cfg_reg,
    .phy_prog_enable_bit, .phy_enhance_bit, .card_rd_idx, .card_rd_data);
  epw_ee_model epw_ee_model_i (.clock, .slow, .reload, .ee_valid,
    .ee_byte, .ee_ready, .ld_byte);
  always #50 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic idle();
    for (int n = 0; n < 80 && write_busy !== 1'b0; n++) @(negedge clock);
    chk("write_busy", 32'h0, {31'h0, write_busy});
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{3'h0, 12'h930, 32'hA1B2C3D4, 12'h934, 32'h5A3C0807,
                8'h00, 64'hA1B2C3D4_5A3C0807};
    rows[1] = '{3'h1, 12'h938, 32'h11223344, 12'h93C, 32'h55667788,
                8'h08, 64'h11223344_55667788};
    rows[2] = '{3'h2, 12'h950, 32'h99AABBCC, 12'h954, 32'hDDEEFF01,
                8'h10, 64'h99AABBCC_DDEEFF01};
    rows[3] = '{3'h3, 12'h958, 32'h0F1E2D3C, 12'h95C, 32'h4B5A6978,
                8'h18, 64'h0F1E2D3C_4B5A6978};
    rows[4] = '{3'h4, 12'h960, 32'h00000107, 12'h960, 32'h00000107,
                8'h20, 64'h00000107_00000000};
    rows[5] = '{3'h5, 12'h980, 32'hCAFE0001, 12'h984, 32'hBEEF0002,
                8'h28, 64'hCAFE0001_BEEF0002};
    rows[6] = '{3'h5, 12'h980, 32'hCAFE0003, 12'h984, 32'hBEEF0004,
                8'h30, 64'hCAFE0003_BEEF0004};
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    for (int i = 0; i < 7; i++) begin
      slow = i[0];
      n0 = epw_ee_model_i.cnt;
      wr(rows[i].oa, rows[i].wa);
      wr(rows[i].ob, rows[i].wb);
      wr(12'h940, {25'h0, rows[i].page, 4'h1});
      chk("write_busy", 32'h1, {31'h0, write_busy});
      idle();
      chk("byte_count", 32'h8, epw_ee_model_i.cnt - n0);
      for (int k = 0; k < 8; k++)
        chk("ee_image", {24'h0, rows[i].img[63-8*k -: 8]},
            {24'h0, epw_ee_model_i.mem[rows[i].base + k]});
    end
    rd(12'h93C, 32'h55667788);
    rd(12'h900, 32'h0);
    rd(12'h950, 32'h99AABBCC);
    rd(12'h940, 32'h0);
    wr(12'h940, 32'h00000010);
    wr(12'h940, 32'h00000061);
    chk("write_busy", 32'h0, {31'h0, write_busy});
    chk("uid_low_target", 32'h0, unique_id_low_reg);
    slow = 1'b1;
    n0 = epw_ee_model_i.cnt;
    wr(12'h940, 32'h00000011);
    wr(12'h938, 32'hFFFFFFFF);
    wr(12'h940, 32'h00000001);
    idle();
    chk("byte_count", 32'h8, epw_ee_model_i.cnt - n0);
    chk("ee_image", 32'h44, {24'h0, epw_ee_model_i.mem[11]});
    reset_n = 1'b0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    chk("prog_bit", 32'h1, {31'h0, phy_prog_enable_bit});
    rd(12'h960, 32'h00000200);
    reload = 1'b1;
    @(negedge clock);
    reload = 1'b0;
    repeat (180) @(negedge clock);
    chk("uid_low_target", 32'h55667788, unique_id_low_reg);
    chk("user0", 32'h99AABBCC, user_cfg_reg[31:0]);
    chk("user3", 32'h4B5A6978, user_cfg_reg[127:96]);
    chk("prog_bit", 32'h0, {31'h0, phy_prog_enable_bit});
    chk("enh_bit", 32'h1, {31'h0, phy_enhance_bit});
    card_rd_idx = 5'h02;
    @(negedge clock);
    chk("card_word", 32'hCAFE0003, card_rd_data);
    chk("ident_target", 32'hA1B2C3D4, subsys_ident_reg);
    chk("latency_target", 32'h5A3C0807, latency_reg);
    chk("uid_high_target", 32'h11223344, unique_id_high_reg);
    reset_n = 1'b0;
    @(negedge clock);
    chk("prog_bit", 32'h1, {31'h0, phy_prog_enable_bit});
    chk("enh_bit", 32'h0, {31'h0, phy_enhance_bit});
    chk("uid_low_target", 32'h0, unique_id_low_reg);
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    wrap_up();
  end
endmodule
bind epw_page_writer epw_page_writer_chk epw_page_writer_chk_i (.clock,
  .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .write_busy, .ee_valid, .ee_ready, .ee_byte);
`default_nettype wire

// ==== epw_page_writer_chk.sv ====
// Port assertions for the parameter page writer
`timescale 1ns/1ps
`default_nettype none
module epw_page_writer_chk (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [11:0]        reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic [31:0]        reg_rdata,
  input wire logic               write_busy,
  input wire logic               ee_valid,
  input wire logic               ee_ready,
  input wire epw_pkg::epw_byte_t ee_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_ctl;
    reg_wr && reg_addr == 12'h940 && !write_busy;
  endsequence
  sequence s_take;
    ee_valid && ee_ready;
  endsequence
  AST_PARAM_RD: assert property (
    reg_rd && reg_addr == 12'h940 |=> reg_rdata == 32'h0)
    else $error("parameter write reg read not zero");
  AST_START: assert property (
    s_ctl ##0 reg_wdata[0] && reg_wdata[6:4] <= 3'h5
    |=> write_busy && ee_byte.addr[2:0] == 3'h0)
    else $error("trigger did not start page at its first byte");
  AST_NO_START: assert property (
    s_ctl ##0 !reg_wdata[0] |=> !write_busy)
    else $error("zero trigger started a page");
  AST_BAD_PAGE: assert property (
    s_ctl ##0 reg_wdata[6:4] > 3'h5 |=> !write_busy)
    else $error("undefined page code started a page");
  AST_STEP: assert property (
    s_take ##0 !ee_byte.last
    |=> ee_valid && ee_byte.addr == $past(ee_byte.addr) + 8'h01)
    else $error("byte address not ascending");
  AST_HOLD: assert property (
    ee_valid && !ee_ready |=> ee_valid && $stable(ee_byte))
    else $error("offered byte changed before acceptance");
  AST_LAST_POS: assert property (
    ee_valid |-> ee_byte.last == (ee_byte.addr[2:0] == 3'h7))
    else $error("last flag not on eighth byte");
  AST_END: assert property (
    s_take ##0 ee_byte.last |=> !write_busy)
    else $error("busy held after eighth byte");
  AST_SPAN: assert property (
    $rose(write_busy) |-> ##[8:60] !write_busy)
    else $error("page write length out of bounds");
endmodule
`default_nettype wire

// ==== epw_pkg.sv ====
// Types shared by the parameter page writer
package epw_pkg;
  typedef enum logic [2:0] {
    EPW_PG_IDENT = 3'h0,
    EPW_PG_UID   = 3'h1,
    EPW_PG_USR01 = 3'h2,
    EPW_PG_USR23 = 3'h3,
    EPW_PG_PHY   = 3'h4,
    EPW_PG_CARD  = 3'h5
  } epw_page_t;

  typedef enum logic [1:0] {
    EPW_ST_IDLE = 2'b01,
    EPW_ST_SEND = 2'b10
  } epw_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       last;
  } epw_byte_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [7:0]  data;
  } epw_load_t;
endpackage
